// >>> src/usr_pkg.sv
// package: register map, field positions and types for the receive path
package usr_pkg;
	// register word indices and byte addresses (printed offset 0xf9a is not a multiple of 4)
	localparam logic [11:0] USR_IDX_BAUD_DIVISOR = 12'h0f9a;
	localparam logic [11:0] USR_IDX_CONTROL = 12'h0f9b;
	localparam logic [11:0] USR_IDX_STATUS = 12'h0f9c;
	localparam logic [11:0] USR_IDX_DATA = 12'h0f9d;
	localparam logic [13:0] USR_ADDR_BAUD_DIVISOR = {USR_IDX_BAUD_DIVISOR, 2'b00};
	localparam logic [13:0] USR_ADDR_CONTROL = {USR_IDX_CONTROL, 2'b00};
	localparam logic [13:0] USR_ADDR_STATUS = {USR_IDX_STATUS, 2'b00};
	localparam logic [13:0] USR_ADDR_DATA = {USR_IDX_DATA, 2'b00};
	// control register bit positions
	localparam int USR_CTL_PORT_EN = 0;
	localparam int USR_CTL_SYNC = 1;
	localparam int USR_CTL_CLK_MASTER = 2;
	localparam int USR_CTL_SINGLE = 3;
	localparam int USR_CTL_CONT = 4;
	localparam int USR_CTL_NINE = 5;
	localparam int USR_CTL_WIDE = 6;
	localparam int USR_CTL_RX_IE = 7;
	// status register bit positions
	localparam int USR_STA_NINTH = 0;
	localparam int USR_STA_OVERRUN = 1;
	localparam int USR_STA_RX_FLAG = 2;
	localparam int USR_STA_COUNT = 3;
	// reset values
	localparam logic [15:0] USR_BAUD_RESET = 16'h0000;
	localparam logic [7:0] USR_CTL_RESET = 8'h00;
	// fifo depth and character width
	localparam int USR_FIFO_DEPTH = 2;
	localparam int USR_CHAR_W = 9;

	// receiver sequencer states (link domain)
	typedef enum logic [1:0] {
		USR_RX_IDLE,
		USR_RX_LOW,
		USR_RX_HIGH
	} usr_rx_state_t;

	// one received character
	typedef struct packed {
		logic [8:0] data;
	} usr_char_t;

	// link-domain state
	typedef struct packed {
		usr_rx_state_t st;
		logic [15:0] cnt;
		logic [8:0] shift;
		logic [3:0] bits;
		logic clk_out;
		logic done_tgl;
		logic [8:0] word;
	} usr_link_t;

	// system-domain state
	typedef struct packed {
		logic [15:0] baud;
		logic [7:0] ctl;
		usr_char_t [1:0] fifo;
		logic [1:0] count;
		logic overrun;
		logic ovr_cont;
		logic rx_flag;
		logic irq;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [2:0] tgl_sync;
		logic run;
		logic nine;
		logic [15:0] div;
	} usr_sys_t;
endpackage : usr_pkg

// >>> src/usr_link_rx.sv
// file: link-clock receive shifter, generates clock out and samples data
`timescale 1ns/1ps
module usr_link_rx
	import usr_pkg::*;
(
	input wire logic link_clk_in,
	input wire logic rst_n_in,
	input wire logic run_in,
	input wire logic nine_in,
	input wire logic [15:0] div_in,
	input wire logic rx_in,
	output logic clk_out,
	output logic done_tgl_out,
	output logic [8:0] word_out
);
	usr_link_t s_q; // registered state
	usr_link_t s_d; // next state
	logic [1:0] run_sync_q; // run level crossing, [1] is the usable stage
	logic [1:0] rx_sync_q; // data pin synchroniser, two flops
	logic [3:0] nbits; // bits per character

	// synchronisers: first stage feeds only the second
	always_ff @(posedge link_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			run_sync_q <= 2'b00;
			rx_sync_q <= 2'b00;
		end
		else
		begin
			run_sync_q <= {run_sync_q[0], run_in};
			rx_sync_q <= {rx_sync_q[0], rx_in};
		end
	end

	// nine or eight bits per character
	assign nbits = nine_in ? 4'd9 : 4'd8;

	// next state: clock is high/low each for div+1 link cycles
	always_comb
	begin
		s_d = s_q;
		case (s_q.st)
			USR_RX_IDLE:
			begin
				s_d.clk_out = 1'b0;
				s_d.bits = 4'd0;
				s_d.cnt = div_in;
				if (run_sync_q[1])
					s_d.st = USR_RX_LOW;
			end
			USR_RX_LOW:
			begin
				// low half: count down; the slave model changes data on the rising edge
				if (s_q.cnt == 16'h0000)
				begin
					s_d.cnt = div_in;
					// a stop seen before the first edge ends the run cleanly
					if (s_q.bits == 4'd0 && !run_sync_q[1])
						s_d.st = USR_RX_IDLE;
					else
					begin
						s_d.clk_out = 1'b1;
						s_d.st = USR_RX_HIGH;
					end
				end
				else
					s_d.cnt = s_q.cnt - 16'h0001;
			end
			USR_RX_HIGH:
			begin
				// sample at end of high half, one bit per period
				if (s_q.cnt == 16'h0000)
				begin
					s_d.cnt = div_in;
					s_d.clk_out = 1'b0;
					s_d.shift = {rx_sync_q[1], s_q.shift[8:1]};
					s_d.bits = s_q.bits + 4'd1;
					if (s_q.bits + 4'd1 == nbits)
					begin
						// lsb first; align eight-bit word to bit 0
						s_d.word = nine_in ?
							{rx_sync_q[1], s_q.shift[8:1]} :
							{1'b0, rx_sync_q[1], s_q.shift[8:2]};
						s_d.done_tgl = ~s_q.done_tgl;
						s_d.bits = 4'd0;
						s_d.st = run_sync_q[1] ? USR_RX_LOW : USR_RX_IDLE;
					end
					else
						s_d.st = USR_RX_LOW;
				end
				else
					s_d.cnt = s_q.cnt - 16'h0001;
			end
			default:
				s_d.st = USR_RX_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge link_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign clk_out = s_q.clk_out;
	assign done_tgl_out = s_q.done_tgl;
	assign word_out = s_q.word;

	// clock output only moves while a reception runs
	property p_clk_idle;
		@(posedge link_clk_in) disable iff (!rst_n_in)
		(s_q.st == USR_RX_IDLE) |=> !s_q.clk_out;
	endproperty
	a_clk_idle: assert property (p_clk_idle) else $error("clock high idle");

	// a character ends after the chosen number of bits
	property p_bitcount;
		@(posedge link_clk_in) disable iff (!rst_n_in)
		(s_q.done_tgl != $past(s_q.done_tgl)) |-> s_q.bits == 4'd0;
	endproperty
	a_bitcount: assert property (p_bitcount) else $error("bit count bad");
endmodule : usr_link_rx

// >>> src/usr_top.sv
// file: receive path top, apb registers, fifo and overrun handling
//
// Summary of operation
// - two-entry receive fifo read via data register
// - third full character while full sets overrun
// - on overrun keep stored data, refuse more
// - overrun flag not software writable
// - single mode overrun cleared by data read
// - continuous overrun cleared by disabling reception
// - nine-bit enable shifts nine bits per character
// - status shows ninth bit of oldest character
// - setting single or continuous enable starts reception
// - receive flag set on complete character, interrupt
// - sixteen-bit divisor, read/write, resets zero
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
module usr_top
	import usr_pkg::*;
(
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic link_clk_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic rx_in,
	output logic clk_pin_out,
	output logic clk_pin_oe_n_out,
	output logic irq_out
);
	usr_sys_t s_q; // registered state
	usr_sys_t s_d; // next state
	logic link_clk; // generated master clock (link domain flop)
	logic done_tgl; // link-domain completion toggle
	logic [8:0] link_word; // held character, stable after toggle
	logic setup; // apb access phase
	logic wr_hit; // write access
	logic rd_hit; // read access
	logic [13:0] addr; // word-aligned byte address
	logic char_done; // synchronised completion pulse
	logic data_read; // read of data register pops fifo
	logic accept; // character stored in fifo
	logic pop; // fifo pop
	logic [31:0] rdata; // read mux
	logic mapped; // address hit

	// the shifter runs on the link clock; run, nine and div cross in, the toggle and the word cross back
	usr_link_rx u_link (
		.link_clk_in(link_clk_in),
		.rst_n_in(rst_n_in),
		.run_in(s_q.run),
		.nine_in(s_q.nine),
		.div_in(s_q.div),
		.rx_in(rx_in),
		.clk_out(link_clk),
		.done_tgl_out(done_tgl),
		.word_out(link_word)
	);

	// apb decode; each access answers in its second access cycle, one wait state
	assign setup = psel_in && penable_in && !s_q.pready;
	assign wr_hit = setup && pwrite_in;
	assign rd_hit = setup && !pwrite_in;
	assign addr = paddr_in[13:0];
	assign mapped = (paddr_in[31:14] == 18'h0_0000) && (paddr_in[1:0] == 2'b00)
		&& (addr == USR_ADDR_BAUD_DIVISOR || addr == USR_ADDR_CONTROL
		|| addr == USR_ADDR_STATUS || addr == USR_ADDR_DATA);
	assign data_read = rd_hit && mapped && addr == USR_ADDR_DATA;
	// completion event: third stage differs from second
	assign char_done = s_q.tgl_sync[2] ^ s_q.tgl_sync[1];
	// character arrives while overrun or full is refused
	assign accept = char_done && s_q.ctl[USR_CTL_PORT_EN] && !s_q.overrun
		&& s_q.count != 2'd2;
	assign pop = data_read && s_q.count != 2'd0;

	// read mux; reserved bits read zero
	always_comb
	begin
		rdata = 32'h0000_0000;
		if (addr == USR_ADDR_BAUD_DIVISOR)
			rdata[15:0] = s_q.baud;
		else if (addr == USR_ADDR_CONTROL)
			rdata[7:0] = s_q.ctl;
		else if (addr == USR_ADDR_STATUS)
		begin
			rdata[USR_STA_NINTH] = s_q.fifo[0].data[8];
			rdata[USR_STA_OVERRUN] = s_q.overrun;
			rdata[USR_STA_RX_FLAG] = s_q.rx_flag;
			rdata[USR_STA_COUNT+1:USR_STA_COUNT] = s_q.count;
		end
		else if (addr == USR_ADDR_DATA)
			rdata[7:0] = s_q.fifo[0].data[7:0];
	end

	// next state of the system domain
	always_comb
	begin
		s_d = s_q;
		s_d.tgl_sync = {s_q.tgl_sync[1:0], done_tgl};
		s_d.pready = setup;
		s_d.pslverr = setup && !mapped;
		if (rd_hit)
			s_d.prdata = mapped ? rdata : 32'h0000_0000;
		// register writes
		if (wr_hit && mapped && addr == USR_ADDR_BAUD_DIVISOR)
			s_d.baud = pwdata_in[15:0];
		if (wr_hit && mapped && addr == USR_ADDR_CONTROL)
			s_d.ctl = pwdata_in[7:0];
		// fifo pop: shift oldest out
		if (pop)
		begin
			s_d.fifo[0] = s_q.fifo[1];
			s_d.count = s_q.count - 2'd1;
		end
		// store a character behind any remaining one
		if (accept)
		begin
			if (pop)
				s_d.fifo[s_q.count - 2'd1] = usr_char_t'(link_word);
			else
				s_d.fifo[s_q.count[0]] = usr_char_t'(link_word);
			s_d.count = pop ? s_q.count : s_q.count + 2'd1;
			// single mode stops after one character
			if (s_q.ctl[USR_CTL_SINGLE] && !s_q.ctl[USR_CTL_CONT])
				s_d.ctl[USR_CTL_SINGLE] = 1'b0;
		end
		// overrun: third complete character while full
		if (char_done && s_q.count == 2'd2 && !pop && !s_q.overrun
			&& s_q.ctl[USR_CTL_PORT_EN])
		begin
			s_d.overrun = 1'b1;
			s_d.ovr_cont = s_q.ctl[USR_CTL_CONT];
			if (!s_q.ctl[USR_CTL_CONT])
				s_d.ctl[USR_CTL_SINGLE] = 1'b0;
		end
		// overrun clears only when its cause goes away
		else if (s_q.overrun)
		begin
			if (!s_q.ovr_cont && data_read)
				s_d.overrun = 1'b0;
			if (s_q.ovr_cont && !s_d.ctl[USR_CTL_CONT])
				s_d.overrun = 1'b0;
		end
		// port disable clears overrun, fifo count and both receive enables
		if (!s_d.ctl[USR_CTL_PORT_EN])
		begin
			s_d.overrun = 1'b0;
			s_d.count = 2'd0;
			s_d.ctl[USR_CTL_SINGLE] = 1'b0;
			s_d.ctl[USR_CTL_CONT] = 1'b0;
		end
		// flag is level: data waiting in fifo
		s_d.rx_flag = s_d.count != 2'd0;
		s_d.irq = s_d.rx_flag && s_d.ctl[USR_CTL_RX_IE];
		// master reception runs while a receive enable is set and no overrun is pending
		s_d.run = s_d.ctl[USR_CTL_PORT_EN] && s_d.ctl[USR_CTL_SYNC]
			&& s_d.ctl[USR_CTL_CLK_MASTER] && !s_d.overrun
			&& (s_d.ctl[USR_CTL_SINGLE] || s_d.ctl[USR_CTL_CONT]);
		s_d.nine = s_d.ctl[USR_CTL_NINE];
		// divisor: wide select uses all 16 bits, else low byte
		s_d.div = s_d.ctl[USR_CTL_WIDE] ? s_d.baud :
			{8'h00, s_d.baud[7:0]};
	end

	// state register
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			s_q <= '0;
			s_q.baud <= USR_BAUD_RESET;
			s_q.ctl <= USR_CTL_RESET;
		end
		else
			s_q <= s_d;
	end

	// clock pin output enable (low = driving) in the link domain
	logic oe_n_q; // output enable, registered
	always_ff @(posedge link_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			oe_n_q <= 1'b1;
		else
			oe_n_q <= 1'b0;
	end

	assign prdata_out = s_q.prdata;
	assign pready_out = s_q.pready;
	assign pslverr_out = s_q.pslverr;
	assign irq_out = s_q.irq;
	assign clk_pin_out = link_clk;
	assign clk_pin_oe_n_out = oe_n_q;

	// overrun sets on a completion while full with no pop
	property p_ovr_set;
		@(posedge clock_in) disable iff (!rst_n_in)
		(char_done && s_q.count == 2'd2 && !pop && s_q.ctl[USR_CTL_PORT_EN]
		&& s_d.ctl[USR_CTL_PORT_EN]) |=> s_q.overrun;
	endproperty
	a_ovr_set: assert property (p_ovr_set) else $error("overrun not set");

	// stored characters survive an overrun
	property p_keep;
		@(posedge clock_in) disable iff (!rst_n_in)
		(s_q.overrun && !pop && s_d.ctl[USR_CTL_PORT_EN])
		|=> s_q.fifo == $past(s_q.fifo);
	endproperty
	a_keep: assert property (p_keep) else $error("fifo changed on overrun");

	// fifo never exceeds two
	property p_depth;
		@(posedge clock_in) disable iff (!rst_n_in)
		s_q.count <= 2'd2;
	endproperty
	a_depth: assert property (p_depth) else $error("fifo over two");

	// continuous overrun holds while continuous and port enable stay set
	property p_no_write_clear;
		@(posedge clock_in) disable iff (!rst_n_in)
		(s_q.overrun && s_q.ovr_cont && s_q.ctl[USR_CTL_CONT]
		&& s_d.ctl[USR_CTL_CONT] && s_d.ctl[USR_CTL_PORT_EN])
		|=> s_q.overrun;
	endproperty
	a_no_write_clear: assert property (p_no_write_clear) else $error("overrun lost");

	// single-mode overrun clears on data read
	property p_read_clear;
		@(posedge clock_in) disable iff (!rst_n_in)
		(s_q.overrun && !s_q.ovr_cont && data_read) |=> !s_q.overrun;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("read no clear");

	// continuous-mode overrun clears when continuous drops
	property p_cont_clear;
		@(posedge clock_in) disable iff (!rst_n_in)
		(s_q.overrun && !s_d.ctl[USR_CTL_CONT] && s_q.ovr_cont)
		|=> !s_q.overrun;
	endproperty
	a_cont_clear: assert property (p_cont_clear) else $error("cont no clear");

	// ninth status bit follows the oldest character
	property p_ninth;
		@(posedge clock_in) disable iff (!rst_n_in)
		(rd_hit && addr == USR_ADDR_STATUS)
		|=> prdata_out[USR_STA_NINTH] == $past(s_q.fifo[0].data[8]);
	endproperty
	a_ninth: assert property (p_ninth) else $error("ninth bit wrong");

	// interrupt follows flag and enable
	property p_irq;
		@(posedge clock_in) disable iff (!rst_n_in)
		accept ##1 s_q.ctl[USR_CTL_RX_IE] |-> irq_out;
	endproperty
	a_irq: assert property (p_irq) else $error("irq missing");

	// single enable clears after one accepted character
	property p_single_off;
		@(posedge clock_in) disable iff (!rst_n_in)
		(accept && !s_q.ctl[USR_CTL_CONT]) |=> !s_q.ctl[USR_CTL_SINGLE];
	endproperty
	a_single_off: assert property (p_single_off) else $error("single stuck");

	// divisor write lands in one cycle
	property p_baud;
		@(posedge clock_in) disable iff (!rst_n_in)
		(wr_hit && mapped && addr == USR_ADDR_BAUD_DIVISOR)
		|=> s_q.baud == $past(pwdata_in[15:0]);
	endproperty
	a_baud: assert property (p_baud) else $error("divisor write lost");
endmodule : usr_top

// >>> test/usr_slave_model.sv
// synchronous slave model: shifts characters onto the serial data line
`timescale 1ns/1ps
module usr_slave_model
	import usr_pkg::*;
(
	input wire logic rst_n_in,
	input wire logic sclk_in,
	input wire logic nine_in,
	input wire logic [8:0] base_in,
	output logic data_out
);
	// bits already sent in this frame
	int bit_q;
	// frames finished since reset; each frame sends base plus this
	logic [8:0] idx_q;
	logic [8:0] word;
	assign word = base_in + idx_q;

	// react to both clock edges from the master
	always @(sclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			bit_q <= 0;
			idx_q <= 9'h000;
			data_out <= 1'b0;
		end
		else if (sclk_in)
		begin
			// rising edge: next bit, lsb first, held through the high half
			data_out <= word[bit_q];
			bit_q <= bit_q + 1;
		end
		else if (bit_q == (nine_in ? 9 : 8))
		begin
			// frame over: stale data must not look valid, so invert it
			data_out <= ~data_out;
			bit_q <= 0;
			idx_q <= idx_q + 9'h001;
		end
	end
endmodule : usr_slave_model

// >>> test/tb_top.sv
// self-checking bench for the receive path against a slave model
`timescale 1ns/1ps
module tb_top
	import usr_pkg::*;
;
	// first character value sent by the slave model
	localparam logic [8:0] CHAR_BASE = 9'h1a5;
	logic clock_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic link_clk = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0000_0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic rx;
	logic clk_pin;
	logic clk_oe_n;
	logic irq;
	logic nine_bit = 1'b0;
	logic err;
	logic [31:0] d;
	int miscompares = 0;
	int checks_done = 0;
	// characters the model has sent so far
	int sent = 0;

	usr_top u_usr_top (.clock_in(clock_in), .rst_n_in(rst_n_in),
		.link_clk_in(link_clk), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.rx_in(rx), .clk_pin_out(clk_pin), .clk_pin_oe_n_out(clk_oe_n),
		.irq_out(irq));
	// data and clock go straight to one slave, digital pins only
	usr_slave_model u_usr_slave_model (.rst_n_in(rst_n_in),
		.sclk_in(clk_pin), .nine_in(nine_bit), .base_in(CHAR_BASE),
		.data_out(rx));

	// system clock, and a link clock with an unrelated phase
	always #5 clock_in = ~clock_in;
	initial
	begin
		#37;
		forever #80 link_clk = ~link_clk;
	end

	// one comparison, counted and reported
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			miscompares++;
		end
	endtask : chk

	// one apb transfer; held until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [13:0] a,
		input logic [31:0] wd);
		int n;
		logic ok;
		@(posedge clock_in);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {18'h0_0000, a};
		pwdata <= wd;
		@(posedge clock_in);
		penable <= 1'b1;
		n = 0;
		ok = 1'b0;
		// look mid-cycle; the following rising edge is the one seeing pready
		do
		begin
			@(negedge clock_in);
			n++;
			ok = (pready === 1'b1);
			if (ok)
			begin
				d = prdata;
				err = pslverr;
			end
			@(posedge clock_in);
		end
		while (!ok && n < 50);
		psel <= 1'b0;
		penable <= 1'b0;
		if (!ok)
			chk(32'h0000_0000, 32'h0000_0001);
	endtask : apb

	// poll status until the masked bits match; a timeout shows as error
	task automatic wait_sta(input logic [31:0] m, input logic [31:0] v);
		int n;
		n = 0;
		do
		begin
			apb(1'b0, USR_ADDR_STATUS, 32'h0);
			n++;
		end
		while ((d & m) !== v && n < 1500);
		chk(d & m, v);
	endtask : wait_sta

	// read the data register and compare with the k-th next character
	task automatic rd_char(input int k);
		logic [8:0] c;
		c = CHAR_BASE + 9'(sent + k);
		apb(1'b0, USR_ADDR_DATA, 32'h0);
		chk(d & 32'h0000_00ff, {24'h0, c[7:0]});
	endtask : rd_char

	task automatic t_regs;
		apb(1'b0, USR_ADDR_BAUD_DIVISOR, 32'h0);
		chk(d, 32'h0000_0000);
		apb(1'b1, USR_ADDR_BAUD_DIVISOR, 32'h0000_a5c3);
		apb(1'b0, USR_ADDR_BAUD_DIVISOR, 32'h0);
		chk(d, 32'h0000_a5c3);
		apb(1'b0, USR_ADDR_CONTROL, 32'h0);
		chk(d, 32'h0000_0000);
		// the clock pin is driven once the link clock has ticked
		chk({31'h0, clk_oe_n}, 32'h0000_0000);
		// unmapped address is refused with a zero read
		apb(1'b0, 14'h0000, 32'h0);
		chk({d[31:1], err}, 32'h0000_0001);
		// divisor of two or more keeps sampling behind the synchroniser
		apb(1'b1, USR_ADDR_BAUD_DIVISOR, 32'h0000_0002);
		apb(1'b1, USR_ADDR_CONTROL, 32'h0000_0007);
	endtask : t_regs

	task automatic t_single;
		apb(1'b1, USR_ADDR_CONTROL, 32'h0000_008f);
		wait_sta(32'h0000_001e, 32'h0000_000c);
		chk({31'h0, irq}, 32'h0000_0001);
		apb(1'b0, USR_ADDR_CONTROL, 32'h0);
		chk(d, 32'h0000_0087);
		rd_char(0);
		sent++;
		repeat (4) @(posedge clock_in);
		chk({31'h0, irq}, 32'h0000_0000);
	endtask : t_single

	task automatic t_nine;
		logic [8:0] c;
		c = CHAR_BASE + 9'(sent);
		nine_bit = 1'b1;
		apb(1'b1, USR_ADDR_CONTROL, 32'h0000_002f);
		wait_sta(32'h0000_001e, 32'h0000_000c);
		// ninth bit is read before the data pops the entry
		chk(d & 32'h0000_0001, {31'h0, c[8]});
		rd_char(0);
		sent++;
		apb(1'b1, USR_ADDR_CONTROL, 32'h0000_0007);
		nine_bit = 1'b0;
	endtask : t_nine

	task automatic t_ovr_single;
		apb(1'b1, USR_ADDR_CONTROL, 32'h0000_000f);
		wait_sta(32'h0000_0018, 32'h0000_0008);
		apb(1'b1, USR_ADDR_CONTROL, 32'h0000_000f);
		wait_sta(32'h0000_0018, 32'h0000_0010);
		apb(1'b1, USR_ADDR_CONTROL, 32'h0000_000f);
		wait_sta(32'h0000_001e, 32'h0000_0016);
		rd_char(0);
		apb(1'b0, USR_ADDR_STATUS, 32'h0);
		chk(d & 32'h0000_001e, 32'h0000_000c);
		rd_char(1);
		sent += 3;
	endtask : t_ovr_single

	task automatic t_ovr_cont;
		apb(1'b1, USR_ADDR_CONTROL, 32'h0000_0017);
		wait_sta(32'h0000_001e, 32'h0000_0016);
		apb(1'b1, USR_ADDR_STATUS, 32'h0000_0000);
		apb(1'b0, USR_ADDR_STATUS, 32'h0);
		chk(d & 32'h0000_0002, 32'h0000_0002);
		rd_char(0);
		apb(1'b1, USR_ADDR_CONTROL, 32'h0000_0007);
		apb(1'b0, USR_ADDR_STATUS, 32'h0);
		chk(d & 32'h0000_001e, 32'h0000_000c);
		rd_char(1);
		sent += 3;
	endtask : t_ovr_cont

	task automatic t_port_off;
		apb(1'b1, USR_ADDR_CONTROL, 32'h0000_0017);
		wait_sta(32'h0000_001e, 32'h0000_0016);
		apb(1'b1, USR_ADDR_CONTROL, 32'h0000_0016);
		apb(1'b0, USR_ADDR_STATUS, 32'h0);
		chk(d & 32'h0000_001e, 32'h0000_0000);
		apb(1'b0, USR_ADDR_CONTROL, 32'h0);
		chk(d, 32'h0000_0006);
		sent += 3;
	endtask : t_port_off

	// the one place where the run ends
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : give_verdict

	// main sequence; reset is asynchronous, ten system cycles suffice
	initial
	begin
		repeat (10) @(posedge clock_in);
		rst_n_in <= 1'b1;
		t_regs();
		t_single();
		t_nine();
		t_ovr_single();
		t_ovr_cont();
		t_port_off();
		give_verdict();
	end

	// watchdog: about nine times the expected run length
	initial
	begin
		repeat (80000) @(posedge clock_in);
		miscompares++;
		give_verdict();
	end
endmodule : tb_top
